/* logic/nvrtc_host.sv */
// Functional notes
// - Host holds address steady through write
// - Host keeps strobe high for recovery
// - Host keeps output-drive high writing
// - Never drive both selects low together
module nvrtc_host #(
    parameter int ACC_CYC = nvrtc_pkg::N_ACC
) (
    input  wire logic        I_CLK,        // 250 MHz clock
    input  wire logic        I_RST_N,      // Async reset, active low
    input  wire logic        I_REQ,        // Access request pulse
    input  wire logic        I_WRITE,      // 1 write, 0 read
    input  wire logic        I_CLK_SPACE,  // 1 clock regs, 0 array
    input  wire logic [16:0] I_ADDR,       // Byte address
    input  wire logic [7:0]  I_WDATA,      // Write data
    input  wire logic [7:0]  I_DQ_IN,      // Data pins from device
    input  wire logic        I_IRQ_N,      // Device interrupt pin
    input  wire logic        I_RSTOUT_N,   // Device reset pin
    output logic             O_BUSY,       // Access in progress
    output logic             O_DONE,       // Access finished pulse
    output logic [7:0]       O_RDATA,      // Read data
    output logic             O_REFUSED,    // Request refused pulse
    output logic [16:0]      O_ADDR,       // Address pins
    output logic [7:0]       O_DQ_OUT,     // Data pins out
    output logic             O_DQ_OE,      // Host drives data pins
    output logic             O_MEM_SEL_N,  // Array select
    output logic             O_CLK_SEL_N,  // Clock register select
    output logic             O_WR_N,       // Write strobe
    output logic             O_OUT_EN_N,   // Output drive enable
    output logic             O_IRQ,        // Interrupt seen
    output logic             O_DEV_RESET   // Device holds reset
);
    logic [1:0] rst_sh_q;
    logic       rst_n;
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) rst_sh_q <= 2'h0;
        else rst_sh_q <= {rst_sh_q[0], 1'b1};
    end
    assign rst_n = rst_sh_q[1];

    logic [1:0] pins_s;
    nvrtc_sync #(.W(2)) u_sync (
        .i_clk   (I_CLK),
        .i_rst_n (rst_n),
        .i_d     ({~I_IRQ_N, ~I_RSTOUT_N}),
        .o_q     (pins_s)
    );
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_IRQ       <= 1'b0;
            O_DEV_RESET <= 1'b0;
        end else begin
            O_IRQ       <= pins_s[1];
            O_DEV_RESET <= pins_s[0];
        end
    end

    function automatic logic [7:0] cyc8(input int n);
        cyc8 = (n < 1) ? 8'h01 : 8'(n);
    endfunction

    nvrtc_pkg::nvrtc_state_t st_q;
    logic [7:0] cnt_q;
    logic       start;
    assign start = I_REQ && !O_BUSY && !O_DEV_RESET;

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= nvrtc_pkg::NVRTC_IDLE;
            cnt_q <= 8'h00;
        end else begin
            case (st_q)
                nvrtc_pkg::NVRTC_IDLE: begin
                    if (start) begin
                        if (I_WRITE) begin
                            st_q  <= nvrtc_pkg::NVRTC_WR_SETUP;
                            cnt_q <= 8'h01;
                        end else begin
                            st_q  <= nvrtc_pkg::NVRTC_RD_WAIT;
                            cnt_q <= cyc8(ACC_CYC);
                        end
                    end
                end
                nvrtc_pkg::NVRTC_RD_WAIT: begin
                    if (cnt_q == 8'h01) begin
                        st_q  <= nvrtc_pkg::NVRTC_RECOVER;
                        cnt_q <= cyc8(nvrtc_pkg::N_FLOAT);
                    end else cnt_q <= cnt_q - 8'h01;
                end
                nvrtc_pkg::NVRTC_WR_SETUP: begin
                    st_q  <= nvrtc_pkg::NVRTC_WR_PULSE;
                    cnt_q <= cyc8(nvrtc_pkg::N_WP);
                end
                nvrtc_pkg::NVRTC_WR_PULSE: begin
                    if (cnt_q == 8'h01) begin
                        st_q  <= nvrtc_pkg::NVRTC_WR_HOLD;
                        cnt_q <= cyc8(nvrtc_pkg::N_DH);
                    end else cnt_q <= cnt_q - 8'h01;
                end
                nvrtc_pkg::NVRTC_WR_HOLD: begin
                    if (cnt_q == 8'h01) begin
                        st_q  <= nvrtc_pkg::NVRTC_RECOVER;
                        cnt_q <= cyc8(nvrtc_pkg::N_WR);
                    end else cnt_q <= cnt_q - 8'h01;
                end
                nvrtc_pkg::NVRTC_RECOVER: begin
                    if (cnt_q == 8'h01) st_q <= nvrtc_pkg::NVRTC_IDLE;
                    else cnt_q <= cnt_q - 8'h01;
                end
                default: st_q <= nvrtc_pkg::NVRTC_IDLE;
            endcase
        end
    end

    // Pin drive; registered from next state decisions
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_ADDR      <= 17'h00000;
            O_DQ_OUT    <= 8'h00;
            O_DQ_OE     <= 1'b0;
            O_MEM_SEL_N <= 1'b1;
            O_CLK_SEL_N <= 1'b1;
            O_WR_N      <= 1'b1;
            O_OUT_EN_N  <= 1'b1;
        end else begin
            if (start) begin
                if (I_CLK_SPACE)
                    O_ADDR <= {13'h0000, I_ADDR[3:0]};
                else
                    O_ADDR <= I_ADDR;
                O_DQ_OUT <= I_WDATA;
                O_DQ_OE  <= I_WRITE;
                // One select only, never both
                O_MEM_SEL_N <= I_CLK_SPACE;
                O_CLK_SEL_N <= !I_CLK_SPACE;
                O_OUT_EN_N  <= I_WRITE;
            end else if (st_q == nvrtc_pkg::NVRTC_WR_SETUP) begin
                O_WR_N <= 1'b0;
            end else if (st_q == nvrtc_pkg::NVRTC_WR_PULSE
                         && cnt_q == 8'h01) begin
                O_WR_N      <= 1'b1;
                O_MEM_SEL_N <= 1'b1;
                O_CLK_SEL_N <= 1'b1;
            end else if (st_q == nvrtc_pkg::NVRTC_WR_HOLD
                         && cnt_q == 8'h01) begin
                O_DQ_OE <= 1'b0;
            end else if (st_q == nvrtc_pkg::NVRTC_RD_WAIT
                         && cnt_q == 8'h01) begin
                O_MEM_SEL_N <= 1'b1;
                O_CLK_SEL_N <= 1'b1;
                O_OUT_EN_N  <= 1'b1;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_BUSY    <= 1'b0;
            O_DONE    <= 1'b0;
            O_RDATA   <= 8'h00;
            O_REFUSED <= 1'b0;
        end else begin
            O_REFUSED <= I_REQ && !start;
            if (start) O_BUSY <= 1'b1;
            else if (st_q == nvrtc_pkg::NVRTC_RECOVER && cnt_q == 8'h01)
                O_BUSY <= 1'b0;
            O_DONE <= (st_q == nvrtc_pkg::NVRTC_RECOVER && cnt_q == 8'h01);
            if (st_q == nvrtc_pkg::NVRTC_RD_WAIT && cnt_q == 8'h01)
                O_RDATA <= I_DQ_IN;
        end
    end

    property p_one_sel;
        @(posedge I_CLK) disable iff (!rst_n)
        !(!O_MEM_SEL_N && !O_CLK_SEL_N);
    endproperty
    a_one_sel: assert property (p_one_sel)
        else $error("both selects low");
    property p_wr_oe;
        @(posedge I_CLK) disable iff (!rst_n)
        !O_WR_N |-> O_OUT_EN_N && O_DQ_OE;
    endproperty
    a_wr_oe: assert property (p_wr_oe)
        else $error("output drive during write");
    property p_fall;
        @(posedge I_CLK) disable iff (!rst_n)
        $fell(O_WR_N) |-> !O_MEM_SEL_N || !O_CLK_SEL_N;
    endproperty
    a_fall: assert property (p_fall)
        else $error("strobe fell without select");
    property p_pulse;
        @(posedge I_CLK) disable iff (!rst_n)
        $fell(O_WR_N) |-> !O_WR_N [*3];
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("write pulse too short");
    property p_addr;
        @(posedge I_CLK) disable iff (!rst_n)
        !O_WR_N |-> $stable(O_ADDR);
    endproperty
    a_addr: assert property (p_addr)
        else $error("address moved in write");
    property p_rec;
        @(posedge I_CLK) disable iff (!rst_n)
        $rose(O_WR_N) |-> O_WR_N [*5];
    endproperty
    a_rec: assert property (p_rec)
        else $error("recovery too short");
    property p_clk_addr;
        @(posedge I_CLK) disable iff (!rst_n)
        !O_CLK_SEL_N |-> O_ADDR[16:4] == 13'h0000;
    endproperty
    a_clk_addr: assert property (p_clk_addr)
        else $error("clock address high bits");
    property p_rd;
        @(posedge I_CLK) disable iff (!rst_n)
        !O_OUT_EN_N |-> !O_DQ_OE && O_WR_N;
    endproperty
    a_rd: assert property (p_rd)
        else $error("drive clash on read");
    property p_res;
        @(posedge I_CLK) disable iff (!rst_n)
        O_DEV_RESET && O_BUSY == 1'b0 |=> !O_BUSY;
    endproperty
    a_res: assert property (p_res)
        else $error("access started in device reset");
endmodule

/* logic/nvrtc_pkg.sv */
package nvrtc_pkg;
    localparam int CLK_MHZ     = 250;
    localparam int T_ACC_NS    = 100;
    localparam int T_WP_NS     = 75;
    localparam int T_WR_NS     = 20;
    localparam int T_DS_NS     = 40;
    localparam int T_CYC_NS    = 100;
    localparam int T_FLOAT_NS  = 40;
    localparam int T_DH_NS     = 20;
    localparam int N_ACC   = (T_ACC_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam int N_WP    = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam int N_WR    = (T_WR_NS * CLK_MHZ + 999) / 1000;
    localparam int N_DS    = (T_DS_NS * CLK_MHZ + 999) / 1000;
    localparam int N_CYC   = (T_CYC_NS * CLK_MHZ + 999) / 1000;
    localparam int N_FLOAT = (T_FLOAT_NS * CLK_MHZ + 999) / 1000;
    localparam int N_DH    = (T_DH_NS * CLK_MHZ + 999) / 1000;
    localparam int ADDR_W  = 17;
    localparam int DATA_W  = 8;
    localparam int CLK_REG_W = 4;
    localparam int CNT_W   = 8;
    typedef enum logic [2:0] {
        NVRTC_IDLE, NVRTC_RD_WAIT, NVRTC_WR_SETUP, NVRTC_WR_PULSE,
        NVRTC_WR_HOLD, NVRTC_RECOVER
    } nvrtc_state_t;
endpackage

/* logic/nvrtc_sync.sv */
// Two-stage level synchroniser
module nvrtc_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,   // Clock
    input  wire logic         i_rst_n, // Reset, active low
    input  wire logic [W-1:0] i_d,     // Async level
    output logic      [W-1:0] o_q      // Synchronised level
);
    logic [W-1:0] s1_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= '0;
            o_q  <= '0;
        end else begin
            s1_q <= i_d;
            o_q  <= s1_q;
        end
    end
endmodule

/* verification/nvrtc_dev_model.sv */
// Behavioural memory and clock-register device on the host pins
module nvrtc_dev_model #(
    parameter int ACC = nvrtc_pkg::T_ACC_NS
) (
    input  wire logic [16:0] i_addr,   // Address pins
    input  wire logic [7:0]  i_dq,     // Resolved data pins
    input  wire logic        i_ce_n,   // Array select
    input  wire logic        i_cs_n,   // Clock register select
    input  wire logic        i_we_n,   // Write strobe
    input  wire logic        i_oe_n,   // Output drive enable
    input  wire logic        i_fail,   // Supply out of tolerance
    input  wire logic        i_alarm,  // Alarm match event
    output logic      [7:0]  o_dq,     // Data driven by device
    output logic             o_dq_oe,  // Device drives data pins
    output logic             o_irq_n,  // Interrupt pin
    output logic             o_rst_n   // Reset pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:131071];
    logic [7:0] rtc [0:15]; // Plain BCD byte store
    logic [7:0] rd_val;
    logic       rd_ok;
    logic       wr_act;
    logic       to_clk;
    realtime    t_chg;

    initial begin
        t_chg = 0;
        rd_ok = 1'b0;
        to_clk = 1'b0;
        for (int i = 0; i < 16; i++) begin
            rtc[i] = 8'h00;
        end
    end
    always @(i_addr or i_ce_n or i_cs_n or i_oe_n or i_we_n) begin
        t_chg = $realtime;
    end
    always #1 rd_ok = ($realtime - t_chg) >= ACC;
    assign wr_act = !i_we_n && (i_ce_n ^ i_cs_n) && !i_fail;
    always @(posedge wr_act) to_clk = !i_cs_n;
    always @(negedge wr_act) begin
        if (!i_fail) begin
            if (to_clk) begin
                rtc[i_addr[3:0]] = i_dq;
            end else begin
                mem[i_addr] = i_dq;
            end
        end
    end
    assign rd_val = !i_cs_n ? ((i_addr[3:0] == 4'h0) ? (rtc[0] & 8'hC0)
                             : rtc[i_addr[3:0]]) : mem[i_addr];
    // Bad data until access time has passed
    assign o_dq = rd_ok ? rd_val : ~rd_val;
    assign o_dq_oe = i_we_n && !i_oe_n && (i_ce_n ^ i_cs_n);
    assign o_irq_n = !i_alarm;
    assign o_rst_n = !i_fail;
endmodule

/* verification/nvrtc_host_bench.sv */
module nvrtc_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, req, write, space, irq_n, rstout_n, busy, done;
    logic refused, dq_oe, mem_sel_n, clk_sel_n, wr_n, out_en_n, irq;
    logic dev_reset, dev_oe, fail, alarm;
    logic [16:0] addr, pin_addr;
    logic [7:0]  wdata, rdata, dq_out, dev_dq, dq, pat, q;
    int miscompares, comparisons, wr_cnt;

    always #2 clk = ~clk;
    always @(posedge clk) pat <= pat + 8'h01;
    // Undriven bus shows a moving pattern, not the last value
    assign dq = dq_oe ? dq_out : (dev_oe ? dev_dq : pat);

    nvrtc_host #(.ACC_CYC(nvrtc_pkg::N_ACC)) u_nvrtc_host (
        .I_CLK(clk), .I_RST_N(rst_n), .I_REQ(req), .I_WRITE(write),
        .I_CLK_SPACE(space), .I_ADDR(addr), .I_WDATA(wdata), .I_DQ_IN(dq),
        .I_IRQ_N(irq_n), .I_RSTOUT_N(rstout_n), .O_BUSY(busy),
        .O_DONE(done), .O_RDATA(rdata), .O_REFUSED(refused),
        .O_ADDR(pin_addr), .O_DQ_OUT(dq_out), .O_DQ_OE(dq_oe),
        .O_MEM_SEL_N(mem_sel_n), .O_CLK_SEL_N(clk_sel_n), .O_WR_N(wr_n),
        .O_OUT_EN_N(out_en_n), .O_IRQ(irq), .O_DEV_RESET(dev_reset));
    nvrtc_dev_model u_nvrtc_dev_model (
        .i_addr(pin_addr), .i_dq(dq), .i_ce_n(mem_sel_n),
        .i_cs_n(clk_sel_n), .i_we_n(wr_n), .i_oe_n(out_en_n),
        .i_fail(fail), .i_alarm(alarm), .o_dq(dev_dq), .o_dq_oe(dev_oe),
        .o_irq_n(irq_n), .o_rst_n(rstout_n));

    task automatic end_of_test();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk_bit(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One access; dbl repeats the request while busy, rf expects refusal
    task automatic acc(input logic w, s, input logic [16:0] a,
                       input logic [7:0] d, input logic dbl, rf);
        logic r;
        logic f;
        req <= 1'b1;
        write <= w;
        space <= s;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        req <= dbl;
        @(posedge clk);
        req <= 1'b0;
        chk_bit(busy, !rf);
        r = refused;
        f = 1'b0;
        repeat (2) begin
            @(posedge clk);
            r = r | refused;
        end
        chk_bit(r, dbl | rf);
        if (!rf) begin
            for (int i = 0; i < 200 && !f; i++) begin
                @(posedge clk);
                f = (done === 1'b1);
            end
            chk_bit(f, 1'b1);
            chk_bit(busy, 1'b0);
        end
        q = rdata;
    endtask

    always @(posedge clk) begin
        if (rst_n) begin
            chk_bit((!mem_sel_n & !clk_sel_n) | (dq_oe & dev_oe)
                    | (!wr_n & !out_en_n), 1'b0);
            wr_cnt <= wr_n ? 0 : wr_cnt + 1;
            if (wr_n && wr_cnt != 0) begin
                chk_bit(wr_cnt >= nvrtc_pkg::N_WP, 1'b1);
            end
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
    initial begin
        {clk, rst_n, req, write, space, fail, alarm} = '0;
        addr = '0;
        wdata = '0;
        pat = '0;
        miscompares = 0;
        comparisons = 0;
        wr_cnt = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        acc(1'b1, 1'b0, 17'h1FFFF, 8'hA5, 1'b0, 1'b0);
        acc(1'b1, 1'b0, 17'h00000, 8'h5A, 1'b1, 1'b0);
        acc(1'b0, 1'b0, 17'h1FFFF, 8'h00, 1'b0, 1'b0);
        chk_byte(q, 8'hA5);
        acc(1'b0, 1'b0, 17'h00000, 8'h00, 1'b0, 1'b0);
        chk_byte(q, 8'h5A);
        acc(1'b1, 1'b1, 17'h1FFF7, 8'h23, 1'b0, 1'b0);
        acc(1'b0, 1'b1, 17'h00007, 8'h00, 1'b0, 1'b0);
        chk_byte(q, 8'h23);
        acc(1'b1, 1'b1, 17'h00000, 8'hFF, 1'b0, 1'b0);
        acc(1'b0, 1'b1, 17'h00000, 8'h00, 1'b0, 1'b0);
        chk_byte(q, 8'hC0);
        fail <= 1'b1;
        repeat (6) @(posedge clk);
        chk_bit(dev_reset, 1'b1);
        acc(1'b1, 1'b0, 17'h1FFFF, 8'h00, 1'b0, 1'b1);
        fail <= 1'b0;
        repeat (6) @(posedge clk);
        chk_bit(dev_reset, 1'b0);
        acc(1'b0, 1'b0, 17'h1FFFF, 8'h00, 1'b0, 1'b0);
        chk_byte(q, 8'hA5);
        alarm <= 1'b1;
        repeat (6) @(posedge clk);
        chk_bit(irq, 1'b1);
        alarm <= 1'b0;
        repeat (6) @(posedge clk);
        chk_bit(irq, 1'b0);
        end_of_test();
    end
endmodule
